// ==== verilog/overflow_guard_pkg.sv ====
`default_nettype none
package overflow_guard_pkg;

  // Register reset values and counter maximum
  localparam logic [7:0]  CTRL_INIT        = 8'h18;
  localparam logic [7:0]  RST_CTRL_INIT    = 8'h1F;
  localparam logic [7:0]  COUNTER_RESET    = 8'h00;
  localparam logic [7:0]  COUNTER_MAX      = 8'hFF;

  // Write keys carried in the upper byte of a word write
  localparam logic [7:0]  KEY_COUNTER      = 8'h5A;
  localparam logic [7:0]  KEY_CONTROL      = 8'hA5;
  localparam logic [7:0]  KEY_RST_FLAG     = 8'hA5;
  localparam logic [7:0]  KEY_RST_BITS     = 8'h5A;
  localparam logic [7:0]  RST_FLAG_CLEAR   = 8'h00;

  // Field positions
  localparam int          OVF_BIT          = 7;
  localparam int          MODE_BIT         = 6;
  localparam int          ENABLE_BIT       = 5;
  localparam int          CKS_MSB          = 2;
  localparam int          CKS_LSB          = 0;
  localparam int          WD_FLAG_BIT      = 7;
  localparam int          RST_EN_BIT       = 6;
  localparam int          RST_TYPE_BIT     = 5;

  // Pulse lengths in system clock cycles
  localparam logic [7:0]  OVF_PULSE_CYCLES = 8'h80;
  localparam logic [9:0]  RESET_CYCLES     = 10'h200;

  // Prescaler: divide-by 2,64,128,256,512,1024,4096,8192
  localparam int          PRESCALE_WIDTH   = 13;
  localparam logic [3:0]  DIV_SHIFT [8]    = '{4'h1, 4'h6, 4'h7, 4'h8,
                                               4'h9, 4'hA, 4'hC, 4'hD};

  typedef enum logic [1:0] {
    ST_RUN     = 2'b00,
    ST_STANDBY = 2'b01,
    ST_WAKE    = 2'b11
  } standby_state_t;

endpackage
`default_nettype wire

// ==== verilog/prescale_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface prescale_if;
  logic [2:0] sel;
  logic       run;
  logic       tick;
  modport ctrl (output sel, output run, input tick);
  modport div  (input sel, input run, output tick);
endinterface
`default_nettype wire

// ==== verilog/overflow_guard_prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none
module overflow_guard_prescaler (
  input  wire logic   ref_clk_i,
  input  wire logic   reset_i,
  prescale_if.div     ps
);

  localparam int PRESCALE_WIDTH = overflow_guard_pkg::PRESCALE_WIDTH;

  logic [overflow_guard_pkg::PRESCALE_WIDTH-1:0] count;
  logic [overflow_guard_pkg::PRESCALE_WIDTH-1:0] next_count;
  logic [overflow_guard_pkg::PRESCALE_WIDTH-1:0] mask;

  // Restarts from zero when halted so the first period is always full
  always_comb begin
    mask       = PRESCALE_WIDTH'((1 << overflow_guard_pkg::DIV_SHIFT[ps.sel]) - 1);
    next_count = ps.run ? count + 1'b1 : '0;
    ps.tick    = ps.run && ((count & mask) == mask);
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule
`default_nettype wire

// ==== verilog/overflow_guard_timer.sv ====
// Summary of operation
// - Watchdog overflow drives overflow_out_n low 128 cycles
// - Reset enabled: internal reset 512 cycles, same start
// - Reset type bit picks power-on or manual
// - External reset wins, clears watchdog flag
// - Port registers cleared only by external reset
// - Interval mode: interrupt on every overflow except the wrap that ends wake-up
// - Interval flag set with interrupt request
// - Watchdog flag set with overflow output
// - Standby refused while counting enabled
// - NMI wakes; counter wrap ends standby
// - Counter write beats simultaneous increment
// - No chip reset: counter and control reset
// - Clock select picks one of eight dividers
// - Keyed word write to counter or control
// - Disabled counter held at zero outside standby and wake-up
// - Keyed reset control writes: clear flag, bits
`timescale 1ns/1ps
`default_nettype none
module overflow_guard_timer (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        external_reset_pin_n_i,
  input  wire logic        wr_strobe_i,
  input  wire logic        wr_rst_ctrl_sel_i,
  input  wire logic [15:0] wr_data_i,
  input  wire logic        rd_ctrl_i,
  input  wire logic        standby_req_i,
  input  wire logic        nmi_i,
  output logic      [7:0]  timer_ctrl_status_o,
  output logic      [7:0]  up_counter_o,
  output logic      [7:0]  reset_ctrl_status_o,
  output logic             overflow_out_n_o,
  output logic             chip_reset_o,
  output logic             chip_reset_manual_o,
  output logic             interval_interrupt_o,
  output logic             standby_allow_o,
  output logic             clock_stop_o,
  output logic             port_regs_reset_o
);

  prescale_if ps ();

  overflow_guard_prescaler u_prescaler (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .ps        (ps.div)
  );

  // Pin synchroniser; only the second stage is used
  logic ext_pin_meta;
  logic ext_pin_sync;
  logic ext_reset;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ext_pin_meta <= 1'b1;
      ext_pin_sync <= 1'b1;
    end else begin
      ext_pin_meta <= external_reset_pin_n_i;
      ext_pin_sync <= ext_pin_meta;
    end
  end

  assign ext_reset = !ext_pin_sync;

  // Register state
  logic       interval_overflow_flag;
  logic       mode_select_bit;
  logic       count_enable_bit;
  logic [2:0] clock_select;
  logic [7:0] up_counter;
  logic       watchdog_overflow_flag;
  logic       reset_enable_bit;
  logic       reset_type_bit;
  logic       ovf_read_armed;

  logic       next_interval_overflow_flag;
  logic       next_mode_select_bit;
  logic       next_count_enable_bit;
  logic [2:0] next_clock_select;
  logic [7:0] next_up_counter;
  logic       next_watchdog_overflow_flag;
  logic       next_reset_enable_bit;
  logic       next_reset_type_bit;
  logic       next_ovf_read_armed;

  // Pulse and standby state
  overflow_guard_pkg::standby_state_t state;
  overflow_guard_pkg::standby_state_t next_state;
  logic [7:0] ovf_pulse_count;
  logic [7:0] next_ovf_pulse_count;
  logic [9:0] reset_count;
  logic [9:0] next_reset_count;
  logic       reset_manual;
  logic       next_reset_manual;

  // Decoded write requests and count events
  logic       wr_counter;
  logic       wr_control;
  logic       wr_rst_flag;
  logic       wr_rst_bits;
  logic       counting;
  logic       increment;
  logic       wrap;
  logic       wd_overflow;
  logic       it_overflow;
  logic       wake_done;

  always_comb begin
    wr_counter  = wr_strobe_i && !wr_rst_ctrl_sel_i
                  && wr_data_i[15:8] == overflow_guard_pkg::KEY_COUNTER;
    wr_control  = wr_strobe_i && !wr_rst_ctrl_sel_i
                  && wr_data_i[15:8] == overflow_guard_pkg::KEY_CONTROL;
    wr_rst_flag = wr_strobe_i && wr_rst_ctrl_sel_i
                  && wr_data_i[15:8] == overflow_guard_pkg::KEY_RST_FLAG
                  && wr_data_i[7:0] == overflow_guard_pkg::RST_FLAG_CLEAR;
    wr_rst_bits = wr_strobe_i && wr_rst_ctrl_sel_i
                  && wr_data_i[15:8] == overflow_guard_pkg::KEY_RST_BITS;
    // During wake-up the counter runs although the enable bit is clear
    counting    = (state == overflow_guard_pkg::ST_RUN && count_enable_bit)
                  || state == overflow_guard_pkg::ST_WAKE;
    increment   = counting && ps.tick && !wr_counter;
    wrap        = increment && up_counter == overflow_guard_pkg::COUNTER_MAX;
    wd_overflow = wrap && state == overflow_guard_pkg::ST_RUN && mode_select_bit;
    it_overflow = wrap && state == overflow_guard_pkg::ST_RUN && !mode_select_bit;
    wake_done   = wrap && state == overflow_guard_pkg::ST_WAKE;
  end

  // Clock select is held through standby, so waking counts at the old rate
  assign ps.sel = clock_select;
  assign ps.run = counting;

  // Register next values
  always_comb begin
    next_interval_overflow_flag = interval_overflow_flag;
    next_mode_select_bit        = mode_select_bit;
    next_count_enable_bit       = count_enable_bit;
    next_clock_select           = clock_select;
    next_up_counter             = up_counter;
    next_watchdog_overflow_flag = watchdog_overflow_flag;
    next_reset_enable_bit       = reset_enable_bit;
    next_reset_type_bit         = reset_type_bit;
    next_ovf_read_armed         = ovf_read_armed;

    if (rd_ctrl_i && interval_overflow_flag) begin
      next_ovf_read_armed = 1'b1;
    end

    if (wr_control) begin
      next_mode_select_bit  = wr_data_i[overflow_guard_pkg::MODE_BIT];
      next_count_enable_bit = wr_data_i[overflow_guard_pkg::ENABLE_BIT];
      next_clock_select     = wr_data_i[overflow_guard_pkg::CKS_MSB:overflow_guard_pkg::CKS_LSB];
      // Flag only clears after it was read as one
      if (!wr_data_i[overflow_guard_pkg::OVF_BIT] && ovf_read_armed) begin
        next_interval_overflow_flag = 1'b0;
        next_ovf_read_armed         = 1'b0;
      end
    end

    if (wr_counter) begin
      next_up_counter = wr_data_i[7:0];
    end else if (increment) begin
      next_up_counter = up_counter + 8'h01;
    end

    if (!count_enable_bit && state == overflow_guard_pkg::ST_RUN) begin
      next_up_counter = overflow_guard_pkg::COUNTER_RESET;
    end

    if (wr_rst_flag) begin
      next_watchdog_overflow_flag = 1'b0;
    end
    if (wr_rst_bits) begin
      next_reset_enable_bit = wr_data_i[overflow_guard_pkg::RST_EN_BIT];
      next_reset_type_bit   = wr_data_i[overflow_guard_pkg::RST_TYPE_BIT];
    end

    // Set beats a clear in the same cycle
    if (it_overflow) begin
      next_interval_overflow_flag = 1'b1;
    end
    if (wd_overflow) begin
      next_watchdog_overflow_flag = 1'b1;
      // Counter and control return to reset; reset control is kept
      next_up_counter             = overflow_guard_pkg::COUNTER_RESET;
      next_interval_overflow_flag = overflow_guard_pkg::CTRL_INIT[overflow_guard_pkg::OVF_BIT];
      next_mode_select_bit        = overflow_guard_pkg::CTRL_INIT[overflow_guard_pkg::MODE_BIT];
      next_count_enable_bit       = overflow_guard_pkg::CTRL_INIT[overflow_guard_pkg::ENABLE_BIT];
      next_clock_select           = overflow_guard_pkg::CTRL_INIT[2:0];
      next_ovf_read_armed         = 1'b0;
    end

    if (standby_req_i && state == overflow_guard_pkg::ST_RUN && !count_enable_bit) begin
      // Upper control bits and reset control clear; clock select kept, counter held at zero
      next_interval_overflow_flag = 1'b0;
      next_mode_select_bit        = 1'b0;
      next_watchdog_overflow_flag = 1'b0;
      next_reset_enable_bit       = 1'b0;
      next_reset_type_bit         = 1'b0;
      next_ovf_read_armed         = 1'b0;
    end

    if (ext_reset) begin
      next_interval_overflow_flag = 1'b0;
      next_mode_select_bit        = 1'b0;
      next_count_enable_bit       = 1'b0;
      next_clock_select           = overflow_guard_pkg::CTRL_INIT[2:0];
      next_up_counter             = overflow_guard_pkg::COUNTER_RESET;
      next_watchdog_overflow_flag = 1'b0;
      next_reset_enable_bit       = 1'b0;
      next_reset_type_bit         = 1'b0;
      next_ovf_read_armed         = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      interval_overflow_flag <= 1'b0;
      mode_select_bit        <= 1'b0;
      count_enable_bit       <= 1'b0;
      clock_select           <= overflow_guard_pkg::CTRL_INIT[2:0];
      up_counter             <= overflow_guard_pkg::COUNTER_RESET;
      watchdog_overflow_flag <= 1'b0;
      reset_enable_bit       <= 1'b0;
      reset_type_bit         <= 1'b0;
      ovf_read_armed         <= 1'b0;
    end else begin
      interval_overflow_flag <= next_interval_overflow_flag;
      mode_select_bit        <= next_mode_select_bit;
      count_enable_bit       <= next_count_enable_bit;
      clock_select           <= next_clock_select;
      up_counter             <= next_up_counter;
      watchdog_overflow_flag <= next_watchdog_overflow_flag;
      reset_enable_bit       <= next_reset_enable_bit;
      reset_type_bit         <= next_reset_type_bit;
      ovf_read_armed         <= next_ovf_read_armed;
    end
  end

  // Overflow pin and internal reset pulses, plus standby sequencing
  always_comb begin
    next_ovf_pulse_count = ovf_pulse_count;
    next_reset_count     = reset_count;
    next_reset_manual    = reset_manual;
    next_state           = state;

    if (ovf_pulse_count != 8'h00) begin
      next_ovf_pulse_count = ovf_pulse_count - 8'h01;
    end
    if (reset_count != 10'h000) begin
      next_reset_count = reset_count - 10'h001;
    end

    if (wd_overflow) begin
      next_ovf_pulse_count = overflow_guard_pkg::OVF_PULSE_CYCLES;
      if (reset_enable_bit) begin
        next_reset_count  = overflow_guard_pkg::RESET_CYCLES;
        next_reset_manual = reset_type_bit;
      end
    end

    case (state)
      overflow_guard_pkg::ST_RUN: begin
        if (standby_req_i && !count_enable_bit) begin
          next_state = overflow_guard_pkg::ST_STANDBY;
        end
      end
      overflow_guard_pkg::ST_STANDBY: begin
        if (nmi_i) begin
          next_state = overflow_guard_pkg::ST_WAKE;
        end
      end
      overflow_guard_pkg::ST_WAKE: begin
        if (wake_done) begin
          next_state = overflow_guard_pkg::ST_RUN;
        end
      end
      default: begin
        next_state = overflow_guard_pkg::ST_RUN;
      end
    endcase

    // External reset takes priority over a coincident watchdog reset
    if (ext_reset) begin
      next_ovf_pulse_count = 8'h00;
      next_reset_count     = 10'h000;
      next_reset_manual    = 1'b0;
      next_state           = overflow_guard_pkg::ST_RUN;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ovf_pulse_count <= 8'h00;
      reset_count     <= 10'h000;
      reset_manual    <= 1'b0;
      state           <= overflow_guard_pkg::ST_RUN;
    end else begin
      ovf_pulse_count <= next_ovf_pulse_count;
      reset_count     <= next_reset_count;
      reset_manual    <= next_reset_manual;
      state           <= next_state;
    end
  end

  // Reserved bits read as one
  assign timer_ctrl_status_o = {interval_overflow_flag, mode_select_bit, count_enable_bit,
                                overflow_guard_pkg::CTRL_INIT[4:3], clock_select};
  assign up_counter_o        = up_counter;
  assign reset_ctrl_status_o = {watchdog_overflow_flag, reset_enable_bit, reset_type_bit,
                                overflow_guard_pkg::RST_CTRL_INIT[4:0]};

  assign overflow_out_n_o     = ovf_pulse_count == 8'h00;
  assign chip_reset_o         = reset_count != 10'h000;
  assign chip_reset_manual_o  = reset_manual;
  assign interval_interrupt_o = interval_overflow_flag;
  assign standby_allow_o      = !count_enable_bit && state == overflow_guard_pkg::ST_RUN;
  assign clock_stop_o         = state != overflow_guard_pkg::ST_RUN;
  // Watchdog reset never reaches the port registers
  assign port_regs_reset_o    = ext_reset;

endmodule
`default_nettype wire

// ==== verification/overflow_guard_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module overflow_guard_props (
  input wire logic       ref_clk_i,
  input wire logic       reset_i,
  input wire logic [7:0] timer_ctrl_status_o,
  input wire logic [7:0] up_counter_o,
  input wire logic [7:0] reset_ctrl_status_o,
  input wire logic       overflow_out_n_o,
  input wire logic       chip_reset_o,
  input wire logic       interval_interrupt_o,
  input wire logic       standby_allow_o,
  input wire logic       clock_stop_o,
  input wire logic       port_regs_reset_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  logic [9:0] low_cnt;
  logic [9:0] rst_cnt;
  logic [9:0] next_low_cnt;
  logic [9:0] next_rst_cnt;
  always_comb begin
    next_low_cnt = overflow_out_n_o ? 10'h000 : low_cnt + 10'h001;
    next_rst_cnt = chip_reset_o ? rst_cnt + 10'h001 : 10'h000;
  end
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      low_cnt <= 10'h000;
      rst_cnt <= 10'h000;
    end else begin
      low_cnt <= next_low_cnt;
      rst_cnt <= next_rst_cnt;
    end
  end
  sequence s_wd_fire;
    $fell(overflow_out_n_o);
  endsequence
  sequence s_irq_rise;
    $rose(interval_interrupt_o);
  endsequence
  // External reset may cut pulses short, so it masks the length checks
  a_pin_low_len: assert property (disable iff (reset_i || port_regs_reset_o)
    $rose(overflow_out_n_o) |-> low_cnt == 10'h080) else $error("overflow pin low time wrong");
  a_chip_rst_len: assert property (disable iff (reset_i || port_regs_reset_o)
    $fell(chip_reset_o) |-> rst_cnt == 10'h200) else $error("chip reset length wrong");
  a_rst_with_pin: assert property ($rose(chip_reset_o) |-> s_wd_fire ##0 !port_regs_reset_o)
    else $error("chip reset not aligned with pin");
  a_wd_flag_pin: assert property (s_wd_fire |-> reset_ctrl_status_o[7] && $past(timer_ctrl_status_o[6]))
    else $error("watchdog flag missing at overflow");
  a_wd_self_reset: assert property (s_wd_fire |-> up_counter_o == 8'h00 && timer_ctrl_status_o == 8'h18)
    else $error("counter or control not reset on overflow");
  a_irq_with_flag: assert property (s_irq_rise |-> $rose(timer_ctrl_status_o[7])
    && !$past(timer_ctrl_status_o[6]) && up_counter_o == 8'h00) else $error("interval flag not set with interrupt");
  a_standby_refuse: assert property (timer_ctrl_status_o[5] |-> !standby_allow_o)
    else $error("standby allowed while counting");
  a_stop_needs_idle: assert property ($rose(clock_stop_o) |-> !$past(timer_ctrl_status_o[5]))
    else $error("standby entered while counting");
  a_wake_wrap: assert property ($fell(clock_stop_o) |-> up_counter_o == 8'h00)
    else $error("standby left without counter wrap");
  a_ext_wins: assert property ($rose(port_regs_reset_o) |-> ##2 !reset_ctrl_status_o[7] && overflow_out_n_o)
    else $error("external reset did not win");
  a_held_zero: assert property (!timer_ctrl_status_o[5] && !$past(timer_ctrl_status_o[5]) && !clock_stop_o
    |-> up_counter_o == 8'h00) else $error("stopped counter not at zero");
endmodule
bind overflow_guard_timer overflow_guard_props u_props (.ref_clk_i, .reset_i, .timer_ctrl_status_o,
  .up_counter_o, .reset_ctrl_status_o, .overflow_out_n_o, .chip_reset_o, .interval_interrupt_o,
  .standby_allow_o, .clock_stop_o, .port_regs_reset_o);
`default_nettype wire

// ==== verification/system_reset_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module system_reset_model (
  input  wire logic        ref_clk_i,
  input  wire logic        interval_interrupt_i,
  input  wire logic        reset_req_i,
  output var  logic        external_reset_pin_n_o,
  output var  logic [15:0] irq_gap_o
);
  logic [15:0] since = 16'h0000;
  logic        irq_d = 1'b0;
  initial external_reset_pin_n_o = 1'b1;
  initial irq_gap_o = 16'h0000;
  // Pin follows the system request only, never the overflow pin
  always @(posedge ref_clk_i) begin
    external_reset_pin_n_o <= ~reset_req_i;
    irq_d <= interval_interrupt_i;
    since <= since + 16'h0001;
    if (interval_interrupt_i && !irq_d) begin
      irq_gap_o <= since;
      since <= 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ==== verification/tb_overflow_guard_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_overflow_guard_timer;
  logic        ref_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        wr_strobe_i = 1'b0;
  logic        wr_rst_ctrl_sel_i = 1'b0;
  logic [15:0] wr_data_i = 16'h0000;
  logic        rd_ctrl_i = 1'b0;
  logic        standby_req_i = 1'b0;
  logic        nmi_i = 1'b0;
  logic        pin_req = 1'b0;
  logic        external_reset_pin_n_i;
  logic [7:0]  timer_ctrl_status_o;
  logic [7:0]  up_counter_o;
  logic [7:0]  reset_ctrl_status_o;
  logic        overflow_out_n_o;
  logic        chip_reset_o;
  logic        chip_reset_manual_o;
  logic        interval_interrupt_o;
  logic        standby_allow_o;
  logic        clock_stop_o;
  logic        port_regs_reset_o;
  logic [15:0] irq_gap;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          a;
  int          b;
  int          div_tab [8] = '{2, 64, 128, 256, 512, 1024, 4096, 8192};
  always #2.5 ref_clk_i = ~ref_clk_i;
  overflow_guard_timer u_dut (.ref_clk_i, .reset_i, .external_reset_pin_n_i, .wr_strobe_i, .wr_rst_ctrl_sel_i,
    .wr_data_i, .rd_ctrl_i, .standby_req_i, .nmi_i, .timer_ctrl_status_o, .up_counter_o, .reset_ctrl_status_o,
    .overflow_out_n_o, .chip_reset_o, .chip_reset_manual_o, .interval_interrupt_o, .standby_allow_o,
    .clock_stop_o, .port_regs_reset_o);
  system_reset_model u_sys (.ref_clk_i, .interval_interrupt_i(interval_interrupt_o), .reset_req_i(pin_req),
    .external_reset_pin_n_o(external_reset_pin_n_i), .irq_gap_o(irq_gap));
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkn(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t count %0d exp %0d", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wr(input logic sel, input logic [15:0] w);
    @(posedge ref_clk_i);
    wr_strobe_i <= 1'b1;
    wr_rst_ctrl_sel_i <= sel;
    wr_data_i <= w;
    @(posedge ref_clk_i);
    wr_strobe_i <= 1'b0;
    #1;
  endtask
  task automatic wait_ovf;
    a = 0;
    while (overflow_out_n_o !== 1'b0 && a < 2000) begin
      cyc(1);
      a++;
    end
  endtask
  task automatic t_interval;
    wr(1'b0, 16'hA520);
    chk8(timer_ctrl_status_o, 8'h38);
    wr(1'b0, 16'h5AF0);
    chk8(up_counter_o, 8'hF0);
    for (int i = 0; i < 2; i++) begin
      a = 0;
      while (interval_interrupt_o !== 1'b1 && a < 600) begin
        cyc(1);
        a++;
      end
      chk8(timer_ctrl_status_o, 8'hB8);
      wr(1'b0, 16'hA520);
      chk8(timer_ctrl_status_o, 8'hB8);
      @(posedge ref_clk_i);
      rd_ctrl_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_ctrl_i <= 1'b0;
      wr(1'b0, 16'hA520);
      chk8(timer_ctrl_status_o, 8'h38);
    end
    // Stop first: a running counter is zero only just after a wrap
    wr(1'b0, 16'hA500);
    cyc(1);
    chkn(irq_gap, 512);
    chk8(up_counter_o, 8'h00);
    // Clock select is only changed while stopped
    for (int i = 0; i < 8; i++) begin
      wr(1'b0, 16'hA500);
      wr(1'b0, {8'hA5, 5'h04, i[2:0]});
      a = 0;
      while (up_counter_o !== 8'h01 && a < 9000) begin
        cyc(1);
        a++;
      end
      b = 0;
      while (up_counter_o === 8'h01 && b < 9000) begin
        cyc(1);
        b++;
      end
      chkn(b, div_tab[i]);
    end
    wr(1'b0, 16'hA500);
  endtask
  task automatic t_watchdog(input logic [7:0] rb);
    wr(1'b1, {8'h5A, rb});
    chk8(reset_ctrl_status_o, rb | 8'h1F);
    wr(1'b0, 16'hA560);
    repeat (3) begin
      cyc(400);
      wr(1'b0, 16'h5A00);
    end
    chk8({7'h00, overflow_out_n_o}, 8'h01);
    wait_ovf;
    chk8(reset_ctrl_status_o, rb | 8'h9F);
    chk8(timer_ctrl_status_o ^ up_counter_o, 8'h18);
    chk8({chip_reset_o, chip_reset_manual_o & rb[6], port_regs_reset_o}, {rb[6], rb[6] & rb[5], 1'b0});
    a = 0;
    b = 0;
    while ((chip_reset_o === 1'b1 || overflow_out_n_o === 1'b0) && b < 600) begin
      if (overflow_out_n_o === 1'b0) a++;
      b++;
      cyc(1);
    end
    chkn(a, 128);
    chkn(b, rb[6] ? 512 : 128);
    wr(1'b1, 16'hA500);
    chk8(reset_ctrl_status_o, rb | 8'h1F);
  endtask
  task automatic t_ext_reset;
    wr(1'b1, 16'h5A40);
    wr(1'b0, 16'hA560);
    wr(1'b0, 16'h5AFE);
    wait_ovf;
    pin_req <= 1'b1;
    cyc(6);
    chk8({reset_ctrl_status_o[7], overflow_out_n_o, port_regs_reset_o}, 8'h03);
    pin_req <= 1'b0;
    cyc(6);
    chk8(reset_ctrl_status_o, 8'h1F);
  endtask
  task automatic t_standby(input logic [15:0] w, input logic [7:0] exp);
    wr(1'b0, w);
    chk8({7'h00, standby_allow_o}, exp);
    @(posedge ref_clk_i);
    standby_req_i <= 1'b1;
    @(posedge ref_clk_i);
    standby_req_i <= 1'b0;
    cyc(2);
    chk8({7'h00, clock_stop_o}, exp);
  endtask
  initial begin
    repeat (12) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    cyc(1);
    chk8(timer_ctrl_status_o ^ up_counter_o, 8'h18);
    chk8(reset_ctrl_status_o, 8'h1F);
    t_interval;
    t_watchdog(8'h40);
    t_watchdog(8'h60);
    t_watchdog(8'h00);
    t_ext_reset;
    t_standby(16'hA520, 8'h00);
    // Divide-by-2 gives a 512-cycle settling wait
    t_standby(16'hA500, 8'h01);
    @(posedge ref_clk_i);
    nmi_i <= 1'b1;
    @(posedge ref_clk_i);
    nmi_i <= 1'b0;
    #1;
    a = 0;
    while (clock_stop_o === 1'b1 && a < 1000) begin
      cyc(1);
      a++;
    end
    chkn(a > 500 && a < 1000, 1);
    chk8(up_counter_o, 8'h00);
    finish_test;
  end
  // Whole run is about 40k cycles
  initial begin
    #500000;
    n_mismatch++;
    finish_test;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
endmodule
`default_nettype wire
